// ---- long_range_trigger_timer_bench.sv ----
// Purpose: self-checking bench of the trigger timer
// Assumes: timebase half period 2 cycles, discharge 2 cycles
// Notes: one task for each scenario
`timescale 1ns/1ns
`default_nettype none
module long_range_trigger_timer_bench;
  logic sys_clk, nrst, trigger_i, ext_mode, one_shot, ext_clk, rst_req;
  logic tb_o, tb_oe_n, tb_i, node_i, node_o, node_oe_n, rst_i, d2, d256;
  logic [7:0] cnt;
  int fail_count, n_checks, cyc;
  //////////////////////////////////////////////////////////////////////
  // clock and the two ends
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  ltt_top #(.TB_HALF_CYC(2), .DIS_CYC(2)) ltt_top_inst (.sys_clk(sys_clk),
    .nrst(nrst), .trigger_i(trigger_i), .reset_i(rst_i),
    .timebase_io_i(tb_i), .timebase_io_o(tb_o), .timebase_io_oe_n(tb_oe_n),
    .timing_node_i(node_i), .timing_node_o(node_o),
    .timing_node_oe_n(node_oe_n), .cnt_ff(cnt), .div2_o(d2),
    .div256_o(d256));
  ltt_far_end ltt_far_end_inst (.ext_mode(ext_mode), .one_shot(one_shot),
    .ext_clk(ext_clk), .rst_req(rst_req), .div256_o(d256),
    .timebase_io_o(tb_o), .timebase_io_oe_n(tb_oe_n),
    .timing_node_o(node_o), .timing_node_oe_n(node_oe_n),
    .reset_i(rst_i), .timebase_io_i(tb_i), .timing_node_i(node_i));
  //////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // trigger rise, then counter cleared and node discharged
  task automatic fire(input logic hold);
    int i;
    @(posedge sys_clk) trigger_i <= 1'b1;
    for (i = 0; i < 8 && cnt !== 8'h00; i++) step();
    check({d2, d256, cnt}, 10'h000);
    for (i = 0; i < 4 && node_oe_n !== 1'b0; i++) step();
    check({node_oe_n, node_o}, 2'h0);
    if (!hold) @(posedge sys_clk) trigger_i <= 1'b0;
    step();
  endtask : fire
  task automatic t_idle();
    check({tb_o, tb_oe_n, node_oe_n, d2, d256, cnt}, 13'h17ff);
  endtask : t_idle
  task automatic t_count();
    int i, falls, hi, lo;
    logic last;
    fire(1'b0);
    falls = 0;
    last = tb_o;
    for (i = 0; i < 2000 && d256 !== 1'b1; i++) begin
      step();
      if (last && !tb_o) falls++;
      last = tb_o;
    end
    check(cnt, 8'h80);
    step();
    if (last && !tb_o) falls++;
    check(16'(falls), 16'h0080);
    hi = 0;
    lo = 0;
    for (i = 0; i < 2000 && d256 === 1'b1; i++) begin step(); hi++; end
    for (i = 0; i < 2000 && d256 === 1'b0; i++) begin step(); lo++; end
    check(16'(hi), 16'h01ff);
    check(16'(lo), 16'h0200);
  endtask : t_count
  task automatic t_reset_pin();
    @(posedge sys_clk) rst_req <= 1'b1;
    repeat (6) step();
    check(cnt, 8'hff);
    fire(1'b1);
    repeat (20) step();
    check(d256, 1'b0);
    @(posedge sys_clk) trigger_i <= 1'b0;
    repeat (6) step();
    check(cnt, 8'hff);
    @(posedge sys_clk) rst_req <= 1'b0;
  endtask : t_reset_pin
  task automatic t_oneshot();
    int i;
    @(posedge sys_clk) one_shot <= 1'b1;
    fire(1'b0);
    for (i = 0; i < 2000 && d256 !== 1'b1; i++) step();
    repeat (26) step();
    check({tb_o, d256, cnt}, 10'h3ff);
    @(posedge sys_clk) one_shot <= 1'b0;
  endtask : t_oneshot
  task automatic t_ext();
    @(posedge sys_clk) ext_mode <= 1'b1;
    repeat (6) step();
    check(tb_oe_n, 1'b1);
    fire(1'b0);
    repeat (3) begin
      @(posedge sys_clk) ext_clk <= 1'b0;
      repeat (6) step();
      @(posedge sys_clk) ext_clk <= 1'b1;
      repeat (6) step();
    end
    check({d2, cnt}, 9'h103);
  endtask : t_ext
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst = 1'b0;
    {trigger_i, ext_mode, one_shot, rst_req} = 4'h0;
    ext_clk = 1'b1;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) step();
    t_idle();
    t_count();
    t_reset_pin();
    t_oneshot();
    t_ext();
    results();
  end
endmodule : long_range_trigger_timer_bench
`default_nettype wire

// ---- ltt_far_end.sv ----
// Purpose: far-side circuit on the timer pins
// Assumes: timing capacitor to supply holds the node high
// Notes: a released timebase line shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module ltt_far_end (
  input wire logic ext_mode,
  input wire logic one_shot,
  input wire logic ext_clk,
  input wire logic rst_req,
  input wire logic div256_o,
  input wire logic timebase_io_o,
  input wire logic timebase_io_oe_n,
  input wire logic timing_node_o,
  input wire logic timing_node_oe_n,
  output logic reset_i,
  output logic timebase_io_i,
  output logic timing_node_i
);
  // node: discharge pulls low, counter-only mode grounds it
  assign timing_node_i = !timing_node_oe_n ? timing_node_o : !ext_mode;
  // timebase wire: device drive, outside clock, else released
  assign timebase_io_i = !timebase_io_oe_n ? timebase_io_o :
                         ext_mode ? ext_clk : !timebase_io_o;
  // one-shot: last stage fed back into reset
  assign reset_i = one_shot ? div256_o : rst_req;
endmodule : ltt_far_end
`default_nettype wire

// ---- ltt_pkg.sv ----
// Purpose: constants and types for the long range trigger timer
// Assumes: sys_clk at 100 MHz
// Notes: all timing figures are held in ns and converted to cycles here
// Operation
// - timebase clocks 8-bit counter, divide up to 256
// - outputs: timebase, first stage, eighth stage
// - reset at power-up, or reset high, trigger low
// - rising trigger leaves reset, starts timing
// - trigger discharges node, flips stages, outputs low
// - divide-by-256 output high after 128 falling edges
// - trigger edge overrides an asserted reset
// - divided outputs driven both high and low
package ltt_pkg;
  localparam int unsigned LTT_CLK_MHZ = 100;
  localparam int unsigned LTT_CNT_W = 8;
  // default internal timebase half period
  localparam int unsigned LTT_TB_HALF_NS = 500;
  localparam int unsigned LTT_TB_HALF_CYC =
    (LTT_TB_HALF_NS * LTT_CLK_MHZ) / 1000;
  // discharge pulse length after a trigger
  localparam int unsigned LTT_DIS_NS = 100;
  localparam int unsigned LTT_DIS_CYC =
    (LTT_DIS_NS * LTT_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] LTT_CNT_RST = 8'hff;
  localparam logic [7:0] LTT_CNT_TRIG = 8'h00;
  localparam logic [7:0] LTT_CNT_HALF = 8'h80;
  localparam int unsigned LTT_DIV2_BIT = 0;
  localparam int unsigned LTT_DIV256_BIT = 7;
  typedef enum logic {LTT_IDLE, LTT_RUN} ltt_state_t;
endpackage : ltt_pkg

// ---- ltt_ripple.sv ----
// Purpose: 8-stage binary counter chain of the timer
// Assumes: controls come from logic on sys_clk
// Notes: load_ones has priority over clear, clear over advance
`timescale 1ns/1ns
`default_nettype none
module ltt_ripple #(
  parameter int unsigned WIDTH = ltt_pkg::LTT_CNT_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load_ones,
  input wire logic clear,
  input wire logic adv,
  output logic [WIDTH-1:0] cnt_ff
);
  import ltt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // stage chain: all ones at rest, all zeros on trigger, +1 per edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '1;
    end else if (load_ones) begin
      cnt_ff <= '1;
    end else if (clear) begin
      cnt_ff <= '0;
    end else if (adv) begin
      cnt_ff <= WIDTH'(cnt_ff + 1'b1);
    end
  end
endmodule : ltt_ripple
`default_nettype wire

// ---- ltt_top.sv ----
// Purpose: long range trigger timer, timebase oscillator plus counter
// Assumes: trigger, reset, timebase and node pins are asynchronous
// Notes: internal timebase stops while idle and restarts on a trigger
`timescale 1ns/1ns
`default_nettype none
module ltt_top #(
  parameter int unsigned TB_HALF_CYC = ltt_pkg::LTT_TB_HALF_CYC,
  parameter int unsigned DIS_CYC = ltt_pkg::LTT_DIS_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic trigger_i,
  input wire logic reset_i,
  input wire logic timebase_io_i,
  output logic timebase_io_o,
  output logic timebase_io_oe_n,
  input wire logic timing_node_i,
  output logic timing_node_o,
  output logic timing_node_oe_n,
  output logic [ltt_pkg::LTT_CNT_W-1:0] cnt_ff,
  output logic div2_o,
  output logic div256_o
);
  import ltt_pkg::*;

  logic rst_s1_ff, rst_n;
  logic trg_s1_ff, trg_s2_ff, trg_s3_ff;
  logic rpin_s1_ff, rpin_s2_ff;
  logic tb_s1_ff, tb_s2_ff, tb_s3_ff;
  logic nd_s1_ff, nd_s2_ff;
  logic ext_mode_ff;
  logic [2:0] dis_hist_ff;
  ltt_state_t state_ff;
  logic [15:0] osc_cnt_ff;
  logic [15:0] dis_cnt_ff;
  logic tb_ff, dis_ff;
  logic trig_rise, rst_req, osc_wrap, adv, load_ones;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  // pin synchronisers; third trigger/timebase flop only for edge detect
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_s1_ff <= 1'b0;
      trg_s2_ff <= 1'b0;
      trg_s3_ff <= 1'b0;
      rpin_s1_ff <= 1'b0;
      rpin_s2_ff <= 1'b0;
      tb_s1_ff <= 1'b1;
      tb_s2_ff <= 1'b1;
      tb_s3_ff <= 1'b1;
      nd_s1_ff <= 1'b1;
      nd_s2_ff <= 1'b1;
    end else begin
      trg_s1_ff <= trigger_i;
      trg_s2_ff <= trg_s1_ff;
      trg_s3_ff <= trg_s2_ff;
      rpin_s1_ff <= reset_i;
      rpin_s2_ff <= rpin_s1_ff;
      tb_s1_ff <= timebase_io_i;
      tb_s2_ff <= tb_s1_ff;
      tb_s3_ff <= tb_s2_ff;
      nd_s1_ff <= timing_node_i;
      nd_s2_ff <= nd_s1_ff;
    end
  end

  // event decode
  assign trig_rise = trg_s2_ff & ~trg_s3_ff;
  assign rst_req = rpin_s2_ff & ~trg_s2_ff;
  assign osc_wrap = (osc_cnt_ff == 16'(TB_HALF_CYC - 1));
  // a trigger edge must reach the clear, so it masks the idle hold too
  assign load_ones = ((state_ff == LTT_IDLE) | rst_req) & ~trig_rise;
  // falling timebase edge, own oscillator or external clock
  assign adv = (state_ff == LTT_RUN) & ~dis_ff & (ext_mode_ff ?
    (tb_s3_ff & ~tb_s2_ff) : (osc_wrap & tb_ff));

  ////////////////////////////////////////////////////////////////////////////
  // discharge history: the pin driver and the node synchroniser echo
  // the discharge low level for three cycles after it ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dis_hist_ff <= '0;
    end else begin
      dis_hist_ff <= {dis_hist_ff[1:0], dis_ff};
    end
  end

  // mode: grounded timing node selects external clock; not sampled
  // while our own discharge, or its echo, pulls the node down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_mode_ff <= 1'b0;
    end else if (!dis_ff && (dis_hist_ff == 3'h0)) begin
      ext_mode_ff <= ~nd_s2_ff;
    end
  end

  // run/idle state; trigger edge wins over reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= LTT_IDLE;
    end else if (trig_rise) begin
      state_ff <= LTT_RUN;
    end else if (rst_req) begin
      state_ff <= LTT_IDLE;
    end
  end

  // discharge pulse after trigger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dis_ff <= 1'b0;
      dis_cnt_ff <= '0;
    end else if (trig_rise) begin
      dis_ff <= 1'b1;
      dis_cnt_ff <= 16'(DIS_CYC - 1);
    end else if (dis_cnt_ff != 16'h0000) begin
      dis_cnt_ff <= dis_cnt_ff - 16'h0001;
    end else begin
      dis_ff <= 1'b0;
    end
  end

  // internal timebase oscillator, halted while idle or discharging
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_ff <= 1'b1;
      osc_cnt_ff <= '0;
    end else if (load_ones || dis_ff || trig_rise) begin
      tb_ff <= 1'b1;
      osc_cnt_ff <= '0;
    end else if (osc_wrap) begin
      tb_ff <= ~tb_ff;
      osc_cnt_ff <= '0;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter chain
  ltt_ripple #(.WIDTH(LTT_CNT_W)) u_chain (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load_ones(load_ones),
    .clear(trig_rise),
    .adv(adv),
    .cnt_ff(cnt_ff)
  );

  // pin drivers; divided outputs are push-pull, no enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timebase_io_o <= 1'b1;
      timebase_io_oe_n <= 1'b0;
      timing_node_o <= 1'b0;
      timing_node_oe_n <= 1'b1;
    end else begin
      timebase_io_o <= tb_ff;
      timebase_io_oe_n <= ext_mode_ff;
      timing_node_o <= 1'b0;
      timing_node_oe_n <= ~dis_ff;
    end
  end
  assign div2_o = cnt_ff[LTT_DIV2_BIT];
  assign div256_o = cnt_ff[LTT_DIV256_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // helper: falling edges counted since the last trigger
  logic [7:0] edges_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_ff <= '0;
    end else if (trig_rise) begin
      edges_ff <= '0;
    end else if (adv && !load_ones) begin
      edges_ff <= edges_ff + 8'h01;
    end
  end

  // checks
  a_idle_outs_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_ff == LTT_IDLE && !trig_rise) |=> (div2_o && div256_o))
    else $error("outputs not high in idle");
  a_reset_enters: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (rst_req && !trig_rise) |=> (state_ff == LTT_IDLE))
    else $error("reset request ignored");
  a_trig_starts: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trig_rise |=> (state_ff == LTT_RUN))
    else $error("trigger did not start run");
  a_trig_over_rst: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (trig_rise && rpin_s2_ff) |=> (state_ff == LTT_RUN) ##1 !div256_o)
    else $error("trigger lost against reset");
  a_trig_flips: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trig_rise |=> (cnt_ff == LTT_CNT_TRIG) ##1 !timing_node_oe_n)
    else $error("trigger did not clear and discharge");
  a_half_mark: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ($rose(div256_o) && state_ff == LTT_RUN) |-> (edges_ff == LTT_CNT_HALF))
    else $error("final stage rose at wrong count");
  a_adv_step: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (adv && !load_ones && !trig_rise) |=> (cnt_ff == $past(cnt_ff) + 8'h01))
    else $error("counter did not step");
  a_free_wrap: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (adv && !load_ones && !trig_rise && cnt_ff == LTT_CNT_RST)
    |=> (cnt_ff == LTT_CNT_TRIG))
    else $error("counter did not wrap");
  a_tb_driven: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !ext_mode_ff |=> !timebase_io_oe_n)
    else $error("timebase not driven");
  c_trigger: cover property (@(posedge sys_clk) disable iff (!rst_n)
    trig_rise);
  c_half: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(div256_o) && state_ff == LTT_RUN);
  c_ext: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ext_mode_ff && adv);
  c_oneshot: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == LTT_RUN) ##1 (state_ff == LTT_IDLE));
endmodule : ltt_top
`default_nettype wire
